// ===== test/sba_agent_model.sv
// Behavioural external agent on the far side of the system bus port
module sba_agent_model (
  input  wire logic        clk,
  input  wire logic        want_bus,
  input  wire logic        ok,
  input  wire logic        drive_now,
  input  wire logic        bad,
  input  wire logic [4:0]  drive_cmd,
  input  wire logic [31:0] drive_data,
  input  wire logic        cpu_owns_bus_n,
  input  wire logic        bus_drive_oe,
  input  wire logic        cpu_strobe_n,
  input  wire logic [31:0] shared_addr_data_bus_out,
  input  wire logic [4:0]  shared_command_bus_out,
  output logic             agent_bus_request_n,
  output logic             agent_accept_n,
  output logic             agent_strobe_n,
  output logic [31:0]      shared_addr_data_bus_in,
  output logic [4:0]       shared_command_bus_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] log[$];
  logic [26:0] cyc  = 27'h0;
  logic [36:0] last = 37'h0;
  logic        drv;
  // Request and accept are plain active-low levels
  assign agent_bus_request_n = ~want_bus;
  assign agent_accept_n      = ~ok;
  // Drive only once the processor lets go, unless told to misbehave
  assign drv            = drive_now && (cpu_owns_bus_n || bad);
  assign agent_strobe_n = ~drv;
  // Undriven bus shows its last value inverted, so stale data never matches
  assign {shared_command_bus_in, shared_addr_data_bus_in} = bus_drive_oe ?
    {shared_command_bus_out, shared_addr_data_bus_out} : drv ? {drive_cmd, drive_data} : ~last;
  // Log every processor strobe with its cycle; killed and repeated cycles are logged too
  always @(posedge clk)
  begin
    cyc  <= cyc + 27'h1;
    last <= {shared_command_bus_in, shared_addr_data_bus_in};
    if (cpu_strobe_n === 1'b0)
      log.push_back({cyc, shared_command_bus_out, shared_addr_data_bus_out});
  end
endmodule

// ===== test/system_bus_arbitration_and_write_issue_tb_top.sv
// Self-checking bench for the system bus port against the agent model
module system_bus_arbitration_and_write_issue_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        power_up_init_n = 1'b1;
  logic        agent_bus_request_n, agent_accept_n, agent_strobe_n, cpu_owns_bus_n, cpu_bus_request_n;
  logic        cpu_strobe_n, bus_drive_oe, req_ready, wdata_ready, rx_valid, protocol_error;
  logic        data_rate_slow = 1'b0, req_valid = 1'b0, req_read = 1'b0, wdata_valid = 1'b0;
  logic        want_bus = 1'b0, ok = 1'b0, drive_now = 1'b0, bad = 1'b0;
  logic [4:0]  shared_command_bus_in, shared_command_bus_out, rx_cmd, drive_cmd = 5'h00;
  logic [5:0]  req_size = 6'h00;
  logic [31:0] shared_addr_data_bus_in, shared_addr_data_bus_out, rx_data;
  logic [31:0] req_addr = 32'h0, wdata = 32'h0, drive_data = 32'h0;
  int          n_errors = 0;
  int          n_compared = 0;

  sba_arbiter DUT (.*);
  sba_agent_model AGT (.*);

  // 50 MHz clock
  initial
    forever #10 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs move on falling edges, away from sampling
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic push(int n, logic [31:0] base);
    wdata_valid = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      wdata = base + i;
      cyc(1);
    end
    wdata_valid = 1'b0;
  endtask
  task automatic req(logic rd, logic [31:0] a, logic [5:0] sz);
    req_read  = rd;
    req_addr  = a;
    req_size  = sz;
    req_valid = 1'b1;
    cyc(1);
    req_valid = 1'b0;
  endtask
  // Bounded wait until the port is free, then let the last beat land
  task automatic wait_done();
    int i;
    for (i = 0; i < 300 && req_ready !== 1'b1; i++)
      cyc(1);
    chk("done", req_ready, 1'b1);
    cyc(2);
  endtask
  task automatic owns_after(logic v, int lo, int hi);
    int n;
    for (n = 0; n < 10 && cpu_owns_bus_n !== v; n++)
      cyc(1);
    chk("owns_n", cpu_owns_bus_n, v);
    chk("edges", n >= lo && n <= hi, 1'b1);
  endtask
  task automatic beat(int i, logic [4:0] c, logic [31:0] d, int gap);
    chk("cmd", AGT.log[i][36:32], c);
    chk("data", AGT.log[i][31:0], d);
    if (i > 0)
      chk("gap", AGT.log[i][63:37] - AGT.log[i-1][63:37], gap);
  endtask
  function automatic int ndata();
    ndata = 0;
    foreach (AGT.log[i])
      ndata += AGT.log[i][36];
  endfunction
  task automatic agent_send(logic [4:0] c, logic [31:0] d);
    drive_cmd  = c;
    drive_data = d;
    drive_now  = 1'b1;
    cyc(1);
    drive_now = 1'b0;
    chk("rx_valid", rx_valid, 1'b1);
    chk("rx_data", rx_data, d);
    chk("rx_cmd", rx_cmd, c);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Eight bytes: address, two beats, last tagged; slow rate holds two idle cycles
  task automatic t_write(logic slow);
    data_rate_slow = slow;
    ok = 1'b1;
    AGT.log.delete();
    push(2, 32'hA0);
    req(1'b0, 32'h100, 6'h08);
    wait_done();
    chk("beats", AGT.log.size(), 3);
    beat(0, 5'h0C, 32'h100, 0);
    beat(1, 5'h10, 32'hA0, 1);
    beat(2, 5'h18, 32'hA1, slow ? 3 : 1);
    data_rate_slow = 1'b0;
    $display("write test done");
  endtask
  // Six bytes go out as a four-byte part and the rest at the next word
  task automatic t_split();
    AGT.log.delete();
    push(2, 32'hB0);
    req(1'b0, 32'h200, 6'h06);
    wait_done();
    chk("parts", AGT.log.size(), 4);
    beat(0, 5'h0B, 32'h200, 0);
    beat(1, 5'h18, 32'hB0, 1);
    chk("part_b", AGT.log[2][36:35], 2'h1);
    chk("addr_b", AGT.log[2][31:0], 32'h204);
    beat(3, 5'h18, 32'hB1, 1);
    $display("split test done");
  endtask
  // Accept for one cycle kills the write; it is retried once accept holds
  task automatic t_kill();
    ok = 1'b0;
    AGT.log.delete();
    push(1, 32'hC0);
    req(1'b0, 32'h300, 6'h04);
    cyc(3);
    ok = 1'b1;
    cyc(1);
    ok = 1'b0;
    cyc(4);
    ok = 1'b1;
    wait_done();
    chk("data_cycles", ndata(), 2);
    beat(AGT.log.size() - 1, 5'h18, 32'hC0, 1);
    $display("kill test done");
  endtask
  // Buffer filled until full, then drained by two stalled 32-byte writes
  task automatic t_fifo();
    ok = 1'b0;
    push(16, 32'hF00);
    chk("full", wdata_ready, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      AGT.log.delete();
      req(1'b0, 32'h600 + 32 * k, 6'h20);
      cyc(6);
      ok = 1'b1;
      wait_done();
      chk("beats32", ndata(), 8);
      beat(AGT.log.size() - 1, 5'h18, 32'hF07 + 8 * k, 1);
      ok = 1'b0;
    end
    chk("drained", wdata_ready, 1'b1);
    $display("fifo test done");
  endtask
  // Agent holds the bus while requesting; processor regains it two cycles after release
  task automatic t_arb();
    want_bus = 1'b1;
    owns_after(1'b1, 1, 3);
    chk("oe_ext", bus_drive_oe, 1'b0);
    cyc(20);
    chk("kept", cpu_owns_bus_n, 1'b1);
    agent_send(5'h08, 32'hD0);
    want_bus = 1'b0;
    cyc(1);
    chk("tristate", bus_drive_oe, 1'b0);
    owns_after(1'b0, 1, 1);
    chk("oe_back", bus_drive_oe, 1'b1);
    $display("arbitration test done");
  endtask
  // Read goes slave; a pending write raises the bus request; end of data hands the bus back
  task automatic t_read();
    AGT.log.delete();
    req(1'b1, 32'h400, 6'h04);
    ok = 1'b1;
    cyc(1);
    ok = 1'b0;
    owns_after(1'b1, 1, 1);
    owns_after(1'b0, 2, 2);
    ok = 1'b1;
    owns_after(1'b1, 0, 4);
    beat(0, 5'h03, 32'h400, 0);
    push(1, 32'hE0);
    req(1'b0, 32'h500, 6'h04);
    cyc(1);
    chk("cpu_bus_request_n", cpu_bus_request_n, 1'b0);
    agent_send(5'h18, 32'hE5);
    owns_after(1'b0, 1, 1);
    wait_done();
    beat(AGT.log.size() - 1, 5'h18, 32'hE0, 1);
    $display("read test done");
  endtask
  // Strobe while processor is master hangs the port until warm or cold reset; here cold reset clears it
  task automatic t_err();
    logic p;
    bad       = 1'b1;
    drive_now = 1'b1;
    cyc(1);
    drive_now = 1'b0;
    bad       = 1'b0;
    cyc(1);
    chk("error", protocol_error, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      p = cpu_bus_request_n;
      cyc(1);
      chk("toggle", cpu_bus_request_n, !p);
    end
    chk("hung", req_ready, 1'b0);
    power_up_init_n = 1'b0;
    cyc(1);
    power_up_init_n = 1'b1;
    chk("cold_owns", cpu_owns_bus_n, 1'b0);
    chk("cold_err", protocol_error, 1'b0);
    $display("error test done");
  endtask

  // Main sequence after 16 reset cycles
  initial
  begin
    cyc(16);
    reset = 1'b0;
    chk("rst_owns", cpu_owns_bus_n, 1'b0);
    chk("rst_oe", bus_drive_oe, 1'b1);
    chk("rst_strobe", cpu_strobe_n, 1'b1);
    chk("rst_ready", req_ready, 1'b1);
    t_write(1'b0);
    t_write(1'b1);
    t_split();
    t_kill();
    t_fifo();
    t_arb();
    t_read();
    t_err();
    end_sim();
  end
  // Watchdog far beyond what the tests need
  initial
  begin
    #200000;
    n_errors++;
    end_sim();
  end
endmodule

// ===== verilog/sba_arbiter.sv
// System bus port: mastership arbitration, command issue with kill/retry, write sequencing
//
// Behaviour
// - Processor leaves mastership with agent while the agent request stays asserted.
// - After agent request, hand over after at most one processor request.
// - Agent releasing the bus: processor drives again two cycles later.
// - In slave state with work pending, assert the processor bus request.
// - On protocol error the port hangs and the processor bus request toggles.
// - Pending read: go slave until end-of-data response, then master unless requested.
// - While agent is master, accept every command or data; never stall it.
// - In slave state, resume when agent request drops: master, drive two cycles later; cpu_owns_bus_n also returns only then, with the drive.
// - Warm or cold reset makes the processor bus master.
// - The master keeps driving the bus except when handing over.
// - Command counts as issued after accept is seen two consecutive cycles.
// - Accept dropping after one cycle kills the command; processor retries it.
// - Killed read: release bus one cycle later, regain two cycles after.
// - Write: command cycle with strobe, then data cycles with identifier and strobe.
// - 1-4 bytes use one beat; 5-7 bytes split into 4 plus remainder.
// - Larger writes send 4 bytes per beat; last beat tagged end of data.
// - Write data starts the cycle after issue, at the configured rate.
// - Command bit 4: 0 address cycle with command, 1 data cycle with identifier.
// - Data rate is every cycle, or one beat then two held idle cycles.
module sba_arbiter
  import sba_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        power_up_init_n,
  input  wire logic        agent_bus_request_n,
  input  wire logic        agent_accept_n,
  input  wire logic        agent_strobe_n,
  input  wire logic [31:0] shared_addr_data_bus_in,
  input  wire logic [4:0]  shared_command_bus_in,
  output logic             cpu_owns_bus_n,
  output logic             cpu_bus_request_n,
  output logic             cpu_strobe_n,
  output logic [31:0]      shared_addr_data_bus_out,
  output logic [4:0]       shared_command_bus_out,
  output logic             bus_drive_oe,
  input  wire logic        data_rate_slow,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_read,
  input  wire logic [31:0] req_addr,
  input  wire logic [5:0]  req_size,
  input  wire logic        wdata_valid,
  output logic             wdata_ready,
  input  wire logic [31:0] wdata,
  output logic             rx_valid,
  output logic [31:0]      rx_data,
  output logic [4:0]       rx_cmd,
  output logic             protocol_error
);
`include "sba_defines.svh"

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sba_state_t  state_reg;
  sba_state_t  state_next;
  logic        rst_any;
  logic        agent_req;
  logic        acc_now;
  logic        acc_prev_reg;
  logic        pend_valid_reg;
  logic        pend_read_reg;
  logic [31:0] pend_addr_reg;
  logic [5:0]  pend_size_reg;
  logic        rate_slow_reg;
  logic [3:0]  beat_cnt_reg;
  logic [1:0]  gap_reg;
  logic        owns_n_reg;
  logic        oe_reg;
  logic        strobe_n_reg;
  logic [31:0] ad_reg;
  logic [4:0]  cmd_reg;
  logic        cpu_bus_request_n_n_reg;
  logic        rx_valid_reg;
  logic [31:0] rx_data_reg;
  logic [4:0]  rx_cmd_reg;
  logic [3:0]  plan_beats;
  logic [2:0]  plan_code;
  logic        plan_split;
  logic        fifo_valid;
  logic        fifo_pop;
  logic [31:0] fifo_data;
  logic [4:0]  fifo_count;
  logic        start_ok;
  logic        issue_ok;
  logic        kill;
  logic        bail;
  logic        err_seen;
  logic        rd_eod;
  logic        enter_data;
  logic        load_next;
  logic        wr_done;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Write words wait here; a write starts only when all its beats are present
  sba_fifo #(
    .WIDTH (`SBA_DATA_W),
    .DEPTH (`SBA_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (rst_any),
    .in_valid  (wdata_valid),
    .in_ready  (wdata_ready),
    .in_data   (wdata),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  sba_beat_plan u_plan (
    .size      (pend_size_reg),
    .beats     (plan_beats),
    .size_code (plan_code),
    .split     (plan_split)
  );

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  // Either reset input forces processor mastership
  assign rst_any   = reset || !power_up_init_n;
  // Active-low handshakes, taken as sampled at the rising edge
  assign agent_req = !agent_bus_request_n;
  assign acc_now   = !agent_accept_n;
  assign err_seen  = sba_is_master(state_reg) && (state_reg != SBA_ST_ERROR) && !agent_strobe_n;
  // All beats must be buffered first, since the agent cannot stall a write
  assign start_ok  = pend_valid_reg && (pend_read_reg || fifo_count >= {1'b0, plan_beats});
  assign issue_ok  = (state_reg == SBA_ST_ADDR) && acc_prev_reg && acc_now;
  assign kill      = (state_reg == SBA_ST_ADDR) && acc_prev_reg && !acc_now;
  // Without a pending accept no request is under way, so give the bus up now
  assign bail      = (state_reg == SBA_ST_ADDR) && !acc_prev_reg && agent_req;
  assign rd_eod    = (state_reg == SBA_ST_WAITRD) && !agent_strobe_n &&
                     shared_command_bus_in[`SBA_CYCLE_BIT] && shared_command_bus_in[`SBA_EOD_BIT];
  assign enter_data = issue_ok && !pend_read_reg;
  assign load_next = (state_reg == SBA_ST_DATA) && (beat_cnt_reg != 4'h0) &&
                     ((!strobe_n_reg && !rate_slow_reg) || (strobe_n_reg && gap_reg == 2'h1));
  assign wr_done   = (state_reg == SBA_ST_DATA) && !strobe_n_reg && (beat_cnt_reg == 4'h0);
  assign fifo_pop  = (enter_data || load_next) && fifo_valid;
  assign req_ready = !pend_valid_reg && (state_reg != SBA_ST_ERROR);

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  // Next state of the bus port
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SBA_ST_IDLE:
        if (err_seen)
          state_next = SBA_ST_ERROR;
        else if (agent_req)
          state_next = SBA_ST_EXT;
        else if (start_ok)
          state_next = SBA_ST_ADDR;
      SBA_ST_ADDR:
        if (err_seen)
          state_next = SBA_ST_ERROR;
        else if (issue_ok)
          state_next = pend_read_reg ? SBA_ST_WAITRD : SBA_ST_DATA;
        else if (kill)
          state_next = pend_read_reg ? SBA_ST_RKILL : SBA_ST_KILLW;
        else if (bail)
          state_next = SBA_ST_EXT;
      SBA_ST_DATA:
        if (err_seen)
          state_next = SBA_ST_ERROR;
        else if (wr_done)
          state_next = agent_req ? SBA_ST_EXT : SBA_ST_IDLE;
      SBA_ST_KILLW:
        if (err_seen)
          state_next = SBA_ST_ERROR;
        else
          state_next = agent_req ? SBA_ST_EXT : SBA_ST_ADDR;
      SBA_ST_WAITRD:
        if (rd_eod)
          state_next = agent_req ? SBA_ST_EXT : SBA_ST_REGAIN;
      SBA_ST_RKILL:
        state_next = agent_req ? SBA_ST_EXT : SBA_ST_REGAIN;
      SBA_ST_EXT:
        if (!agent_req)
          state_next = SBA_ST_REGAIN;
      SBA_ST_REGAIN:
        state_next = SBA_ST_IDLE;
      SBA_ST_ERROR:
        state_next = SBA_ST_ERROR;
      default:
        state_next = SBA_ST_ERROR;
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst_any)
      state_reg <= SBA_ST_IDLE;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Request holding
  // ----------------------------------------------------------------
  // One request is held; a 5..7 byte write reloads as its tail after the first part
  always_ff @(posedge clk)
  begin
    if (rst_any)
    begin
      pend_valid_reg <= 1'b0;
      pend_read_reg  <= 1'b0;
      pend_addr_reg  <= 32'h0000_0000;
      pend_size_reg  <= 6'h00;
    end
    else if (req_valid && req_ready)
    begin
      pend_valid_reg <= 1'b1;
      pend_read_reg  <= req_read;
      pend_addr_reg  <= req_addr;
      pend_size_reg  <= req_size;
    end
    else if (issue_ok && pend_read_reg)
      pend_valid_reg <= 1'b0;
    else if (wr_done && plan_split)
    begin
      pend_addr_reg <= pend_addr_reg + 32'h0000_0004;
      pend_size_reg <= pend_size_reg - `SBA_WORD_BYTES;
    end
    else if (wr_done)
      pend_valid_reg <= 1'b0;
  end

  // Accept seen last cycle, and the rate latched for the whole write
  always_ff @(posedge clk)
  begin
    if (rst_any)
    begin
      acc_prev_reg  <= 1'b0;
      rate_slow_reg <= 1'b0;
    end
    else
    begin
      acc_prev_reg <= acc_now;
      if (state_reg == SBA_ST_IDLE)
        rate_slow_reg <= data_rate_slow;
    end
  end

  // ----------------------------------------------------------------
  // Beat sequencing
  // ----------------------------------------------------------------
  // Beats left after the one shown, and idle cycles of the slow pattern
  always_ff @(posedge clk)
  begin
    if (rst_any)
    begin
      beat_cnt_reg <= 4'h0;
      gap_reg      <= 2'h0;
    end
    else if (enter_data)
    begin
      beat_cnt_reg <= plan_beats - 4'h1;
      gap_reg      <= 2'h0;
    end
    else if (load_next)
    begin
      beat_cnt_reg <= beat_cnt_reg - 4'h1;
      gap_reg      <= 2'h0;
    end
    else if (state_reg == SBA_ST_DATA && !strobe_n_reg && rate_slow_reg)
      gap_reg <= `SBA_DXX_IDLE;
    else if (state_reg == SBA_ST_DATA && gap_reg != 2'h0)
      gap_reg <= gap_reg - 2'h1;
  end

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  // Ownership and drive follow the coming state, so both change on the same edge
  always_ff @(posedge clk)
  begin
    if (rst_any)
    begin
      owns_n_reg <= 1'b0;
      oe_reg     <= 1'b1;
    end
    else
    begin
      owns_n_reg <= !sba_is_master(state_next);
      oe_reg     <= sba_is_master(state_next);
    end
  end

  // Strobe, address/data and command; data is held through idle cycles
  always_ff @(posedge clk)
  begin
    if (rst_any)
    begin
      strobe_n_reg <= 1'b1;
      ad_reg       <= 32'h0000_0000;
      cmd_reg      <= 5'h00;
    end
    else if (state_next == SBA_ST_ADDR)
    begin
      // Command is repeated until accepted
      strobe_n_reg <= 1'b0;
      ad_reg       <= pend_addr_reg;
      cmd_reg      <= {1'b0, !pend_read_reg, plan_code};
    end
    else if (enter_data || load_next || state_next == SBA_ST_KILLW)
    begin
      // A killed write still shows its first beat; the agent drops it
      strobe_n_reg <= 1'b0;
      ad_reg       <= fifo_data;
      cmd_reg      <= {1'b1, (load_next ? beat_cnt_reg == 4'h1 : plan_beats == 4'h1), 3'h0};
    end
    else
      strobe_n_reg <= 1'b1;
  end

  // Processor bus request: asserted in slave state with work, toggling after an error
  always_ff @(posedge clk)
  begin
    if (rst_any)
      cpu_bus_request_n_n_reg <= 1'b1;
    else if (state_reg == SBA_ST_ERROR)
      cpu_bus_request_n_n_reg <= !cpu_bus_request_n_n_reg;
    else
      cpu_bus_request_n_n_reg <= !(pend_valid_reg && !sba_is_master(state_reg));
  end

  // ----------------------------------------------------------------
  // Inbound capture
  // ----------------------------------------------------------------
  // Anything the agent strobes while it owns the bus is taken; no stall path exists
  always_ff @(posedge clk)
  begin
    if (rst_any)
    begin
      rx_valid_reg <= 1'b0;
      rx_data_reg  <= 32'h0000_0000;
      rx_cmd_reg   <= 5'h00;
    end
    else
    begin
      rx_valid_reg <= !agent_strobe_n && !sba_is_master(state_reg);
      if (!agent_strobe_n && !sba_is_master(state_reg))
      begin
        rx_data_reg <= shared_addr_data_bus_in;
        rx_cmd_reg  <= shared_command_bus_in;
      end
    end
  end

  assign cpu_owns_bus_n           = owns_n_reg;
  assign cpu_bus_request_n        = cpu_bus_request_n_n_reg;
  assign cpu_strobe_n             = strobe_n_reg;
  assign shared_addr_data_bus_out = ad_reg;
  assign shared_command_bus_out   = cmd_reg;
  assign bus_drive_oe             = oe_reg;
  assign rx_valid                 = rx_valid_reg;
  assign rx_data                  = rx_data_reg;
  assign rx_cmd                   = rx_cmd_reg;
  assign protocol_error           = (state_reg == SBA_ST_ERROR);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst_any);

  sequence s_read_kill;
    (state_reg == SBA_ST_ADDR) && pend_read_reg && acc_prev_reg && !acc_now && !agent_req
    ##1 !agent_req ##1 !agent_req;
  endsequence

  a_ext_hold: assert property ((state_reg == SBA_ST_EXT) && agent_req |=> cpu_owns_bus_n && !bus_drive_oe)
    else $error("processor took the bus while agent request held");
  a_regain_two: assert property ((state_reg == SBA_ST_EXT) && !agent_req |-> ##2 !cpu_owns_bus_n && bus_drive_oe)
    else $error("bus not regained two cycles after release");
  a_slave_req: assert property (!sba_is_master(state_reg) && pend_valid_reg |=> !cpu_bus_request_n)
    else $error("processor bus request missing in slave state");
  a_err_toggle: assert property ((state_reg == SBA_ST_ERROR) ##1 (state_reg == SBA_ST_ERROR)
                                 |-> cpu_bus_request_n != $past(cpu_bus_request_n))
    else $error("processor bus request not toggling after error");
  a_read_release: assert property (issue_ok && pend_read_reg |=> cpu_owns_bus_n && !bus_drive_oe)
    else $error("bus kept after read issue");
  a_issue_two: assert property ((state_reg == SBA_ST_DATA) && ($past(state_reg) == SBA_ST_ADDR)
                                |-> $past(acc_now) && $past(acc_prev_reg))
    else $error("write issued without two accept cycles");
  a_kill_retry: assert property ((state_reg == SBA_ST_KILLW) && !agent_req && !err_seen
                                 |=> (state_reg == SBA_ST_ADDR) && !cpu_strobe_n && !shared_command_bus_out[4])
    else $error("killed write not retried");
  a_read_kill: assert property (s_read_kill |-> cpu_owns_bus_n ##1 !cpu_owns_bus_n)
    else $error("killed read release timing wrong");
  a_first_beat: assert property (enter_data |=> !cpu_strobe_n && shared_command_bus_out[4])
    else $error("write data not right after issue");
  a_dxx_gap: assert property ((state_reg == SBA_ST_DATA) && !cpu_strobe_n && rate_slow_reg && beat_cnt_reg != 4'h0
                              |=> cpu_strobe_n [*2] ##1 !cpu_strobe_n)
    else $error("slow data pattern broken");
  a_reset_master: assert property (@(posedge clk) disable iff (1'b0)
                                   rst_any |=> !cpu_owns_bus_n && bus_drive_oe)
    else $error("reset did not give processor mastership");
endmodule

// ===== verilog/sba_beat_plan.sv
// Splits a write size into beats, a size code and a split flag
module sba_beat_plan
  import sba_pkg::*;
(
  input  wire logic [5:0] size,
  output logic      [3:0] beats,
  output logic      [2:0] size_code,
  output logic            split
);
`include "sba_defines.svh"

  // Small writes: one beat; 5..7 bytes: 4-byte part first; larger: whole words
  always_comb
  begin
    beats     = 4'h1;
    size_code = 3'h3;
    split     = 1'b0;
    if (size <= `SBA_WORD_BYTES)
      size_code = (size == 6'h00) ? 3'h0 : 3'(size - 6'h01);
    else if (size <= `SBA_MAX_SINGLE)
      split = 1'b1;
    else
    begin
      beats = size[5:2] == 4'h0 ? 4'h1 : (size[5] ? 4'h8 : size[5:2]);
      case (size)
        6'h08:   size_code = 3'h4;
        6'h10:   size_code = 3'h5;
        6'h20:   size_code = 3'h6;
        default: size_code = 3'h7;
      endcase
    end
  end
endmodule

// ===== verilog/sba_defines.svh
// Constants of the system bus arbiter: field positions, counts and sizes
`ifndef SBA_DEFINES_SVH
`define SBA_DEFINES_SVH

// Command bus layout
`define SBA_CMD_W        5
`define SBA_CYCLE_BIT    4
`define SBA_EOD_BIT      3
`define SBA_WRITE_BIT    3
`define SBA_DATA_W       32

// Transfer sizes in bytes
`define SBA_WORD_BYTES   6'h04
`define SBA_MAX_SINGLE   6'h07

// Idle cycles after each beat in the slow data pattern
`define SBA_DXX_IDLE     2'h2

// Write buffer depth in words
`define SBA_FIFO_DEPTH   16

`endif

// ===== verilog/sba_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module sba_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0]           mem_reg [DEPTH];
  logic [AW-1:0]              wr_ptr_reg;
  logic [AW-1:0]              rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] count_reg;
  logic                       push;
  logic                       pop;

  // Full and empty come from the occupancy count
  assign in_ready  = (count_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign count     = count_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule

// ===== verilog/sba_pkg.sv
// Types and shared helpers of the system bus arbiter
package sba_pkg;

  // Bus-side states, one-hot
  typedef enum logic [8:0] {
    SBA_ST_IDLE   = 9'h001,
    SBA_ST_ADDR   = 9'h002,
    SBA_ST_DATA   = 9'h004,
    SBA_ST_KILLW  = 9'h008,
    SBA_ST_WAITRD = 9'h010,
    SBA_ST_RKILL  = 9'h020,
    SBA_ST_EXT    = 9'h040,
    SBA_ST_REGAIN = 9'h080,
    SBA_ST_ERROR  = 9'h100
  } sba_state_t;

  // True in states where the processor owns and drives the bus
  function automatic logic sba_is_master(input sba_state_t st);
    sba_is_master = (st == SBA_ST_IDLE) || (st == SBA_ST_ADDR) ||
                    (st == SBA_ST_DATA) || (st == SBA_ST_KILLW) || (st == SBA_ST_ERROR);
  endfunction

endpackage
